// >>> verilog/psam_map.v
// ==========================================================================
`timescale 1ns/1ps
`include "psam_defines.vh"
module psam_map #(
  parameter IMPL_AW = 8 // implemented array depth, log2 locations
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  // execution side
  input  wire        pc_step,
  input  wire        pc_dir_down,
  input  wire        pc_load,
  input  wire [22:0] pc_load_value,
  output reg  [22:0] program_counter,
  output reg  [23:0] fetch_addr,
  output reg         in_vector_area,
  output reg         in_primary_ivt,
  output reg         in_alternate_ivt,
  // table access side
  input  wire        table_read_op,
  input  wire        table_write_op,
  input  wire        table_hi_word,
  input  wire [7:0]  table_page_register,
  input  wire [15:0] table_offset,
  input  wire [15:0] table_wr_data,
  output reg  [15:0] table_rd_data,
  output reg         table_rd_valid,
  output reg         table_denied,
  output reg         table_cfg_access,
  // configuration and identification area, outside this block
  output reg         cfg_rd_req,
  output reg         cfg_wr_req,
  output reg  [23:0] cfg_addr,
  output reg  [15:0] cfg_wr_data,
  input  wire [15:0] cfg_rd_data
);
  // ========================================================================
  // state codes
  localparam ST_IDLE = 3'b001;
  localparam ST_ARR  = 3'b010;
  localparam ST_CFG  = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [23:0] tbl_addr;
  reg         tbl_hi;
  reg         tbl_impl;
  reg  [22:0] next_pc;

  wire [23:0] req_addr;
  wire        page_cfg;
  wire        addr_impl;
  wire        op_any;
  wire [23:0] arr_rd;
  wire [23:0] arr_wr;
  reg         tbl_rd;
  reg  [15:0] tbl_wdata;
  wire [23:0] next_fetch;
  wire        next_vec;
  wire        next_pri;
  wire        next_alt;

  // ========================================================================
  // address formation
  assign req_addr = {table_page_register, table_offset[15:1], 1'b0};
  assign page_cfg = table_page_register[`PSAM_CFG_PAGE_BIT];
  assign op_any   = table_read_op | table_write_op;
  // only the lowest part of the user half is backed by the array
  // limitation: writes beyond it are dropped, reads there give zero
  assign addr_impl = (req_addr[23:1] < (23'h000001 << IMPL_AW));

  // ========================================================================
  // program counter: even, steps by two, reset to zero
  always @* begin
    next_pc = program_counter;
    if (pc_load) begin
      next_pc = {pc_load_value[22:1], 1'b0};
    end else if (pc_step) begin
      if (pc_dir_down) begin
        next_pc = program_counter - `PSAM_PC_STEP;
      end else begin
        next_pc = program_counter + `PSAM_PC_STEP;
      end
    end
  end

  // ========================================================================
  // region decode of the next address; decoding the next value rather
  // than the registered one keeps each flag on the same location as the
  // program counter beside it, with no cycle of lag
  assign next_fetch = {1'b0, next_pc};
  assign next_vec   = (next_fetch < `PSAM_VEC_END);
  assign next_pri   = (next_fetch >= `PSAM_PRI_IVT_LO) &&
                      (next_fetch <= `PSAM_PRI_IVT_HI);
  assign next_alt   = (next_fetch >= `PSAM_ALT_IVT_LO) &&
                      (next_fetch <= `PSAM_ALT_IVT_HI);

  // counter and region flags move together under the enable
  always @(posedge core_clk) begin
    if (!rst_n) begin
      program_counter  <= `PSAM_RESET_ADDR;
      fetch_addr       <= 24'h000000;
      in_vector_area   <= 1'b1;
      in_primary_ivt   <= 1'b0;
      in_alternate_ivt <= 1'b0;
    end else if (clk_en) begin
      program_counter  <= next_pc;
      fetch_addr       <= next_fetch;
      in_vector_area   <= next_vec;
      in_primary_ivt   <= next_pri;
      in_alternate_ivt <= next_alt;
    end
  end

  // ========================================================================
  // table access sequencer
  always @* begin
    next_state = ST_IDLE;
    case (state)
      ST_IDLE: begin
        if (op_any && page_cfg) begin
          next_state = ST_CFG;
        end else if (op_any) begin
          next_state = ST_ARR;
        end
      end
      ST_ARR:  next_state = ST_IDLE;
      ST_CFG:  next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // merge a half-word write into the location read at the take edge, so
  // the other half of the 24-bit location is written back unchanged
  assign arr_wr = tbl_hi ?
                  {tbl_wdata[7:0], arr_rd[15:0]} :
                  {arr_rd[23:16], tbl_wdata};

  // take, busy and answer of one table access; strobes last one cycle
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state            <= ST_IDLE;
      tbl_addr         <= 24'h000000;
      tbl_hi           <= 1'b0;
      tbl_impl         <= 1'b0;
      table_rd_data    <= 16'h0000;
      table_rd_valid   <= 1'b0;
      table_denied     <= 1'b0;
      table_cfg_access <= 1'b0;
      cfg_rd_req       <= 1'b0;
      cfg_wr_req       <= 1'b0;
      cfg_addr         <= 24'h000000;
      cfg_wr_data      <= 16'h0000;
      tbl_rd           <= 1'b0;
      tbl_wdata        <= 16'h0000;
    end else if (clk_en) begin
      state          <= next_state;
      table_rd_valid <= 1'b0;
      table_denied   <= 1'b0;
      cfg_rd_req     <= 1'b0;
      cfg_wr_req     <= 1'b0;
      if (state == ST_IDLE && op_any) begin
        tbl_addr         <= req_addr;
        tbl_hi           <= table_hi_word;
        tbl_rd           <= table_read_op;
        tbl_wdata        <= table_wr_data;
        tbl_impl         <= addr_impl && !page_cfg;
        table_cfg_access <= page_cfg;
        if (page_cfg) begin
          cfg_rd_req  <= table_read_op;
          cfg_wr_req  <= table_write_op;
          cfg_addr    <= req_addr;
          cfg_wr_data <= table_wr_data;
        end
      end
      if (state == ST_ARR) begin
        if (tbl_rd) begin
          // unimplemented user space answers zero, not an error
          table_rd_data <= !tbl_impl ? 16'h0000 :
                           tbl_hi ? {8'h00, arr_rd[23:16]} :
                           arr_rd[15:0];
          table_rd_valid <= 1'b1;
        end
        table_denied <= tbl_addr > `PSAM_USER_TOP;
      end
      if (state == ST_CFG) begin
        // a write into the config area gets no read answer
        if (tbl_rd) begin
          table_rd_data  <= cfg_rd_data;
          table_rd_valid <= 1'b1;
        end
      end
    end
  end

  // ========================================================================
  // program array; write lands on the cycle after the read compare
  wire wr_go;
  assign wr_go = (state == ST_ARR) && table_write_op && tbl_impl;

  psam_rom #(
    .AW (IMPL_AW),
    .DW (`PSAM_INSTR_W)
  ) u_rom (
    .core_clk (core_clk),
    .clk_en   (clk_en),
    .wr_en    (wr_go),
    .wr_addr  (tbl_addr[IMPL_AW:1]),
    .wr_data  (arr_wr),
    .rd_addr  (req_addr[IMPL_AW:1]),
    .rd_data  (arr_rd)
  );
endmodule

// >>> verilog/psam_defines.vh
`ifndef PSAM_DEFINES_VH
`define PSAM_DEFINES_VH
// ==========================================================================
// program space address map constants
`define PSAM_ADDR_W        24
`define PSAM_PC_W          23
`define PSAM_WORD_W        16
`define PSAM_INSTR_W       24
`define PSAM_LOC_COUNT     24'h400000
`define PSAM_USER_TOP      24'h7fffff
`define PSAM_CFG_PAGE_BIT  7
`define PSAM_PC_STEP       23'h000002
`define PSAM_RESET_ADDR    23'h000000
`define PSAM_GOTO_TGT_ADDR 24'h000002
`define PSAM_PRI_IVT_LO    24'h000004
`define PSAM_PRI_IVT_HI    24'h0000ff
`define PSAM_ALT_IVT_LO    24'h000100
`define PSAM_ALT_IVT_HI    24'h0001ff
`define PSAM_VEC_END       24'h000200
`endif

// >>> verilog/psam_rom.v
`timescale 1ns/1ps
// ==========================================================================
// small synchronous memory, registered read data
module psam_rom #(
  parameter AW = 8,
  parameter DW = 24
) (
  input  wire          core_clk,
  input  wire          clk_en,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // one write port, one registered read port
  always @(posedge core_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// >>> test/psam_map_assertions.sv
`timescale 1ns/1ps
// ==================
// map checker
module psam_chk (
  input wire        core_clk,
  input wire        rst_n,
  input wire        clk_en,
  input wire        pc_step,
  input wire        pc_dir_down,
  input wire        pc_load,
  input wire [22:0] program_counter,
  input wire [23:0] fetch_addr,
  input wire        in_vector_area,
  input wire        in_primary_ivt,
  input wire        in_alternate_ivt,
  input wire        cfg_rd_req,
  input wire        cfg_wr_req,
  input wire [23:0] cfg_addr,
  input wire        table_rd_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_pc_step: assert property (
    clk_en && pc_step && !pc_load |=> program_counter == $past(program_counter)
    + ($past(pc_dir_down) ? 23'h7ffffe : 23'h000002)) else $error("pc step");
  a_pc_frozen: assert property (
    !clk_en |=> $stable(program_counter)) else $error("pc moved");
  a_fetch_form: assert property (
    fetch_addr == {1'b0, program_counter}) else $error("fetch addr");
  a_vector_area: assert property (
    in_vector_area == (program_counter < 23'h000200)) else $error("vec");
  a_primary_ivt: assert property (
    in_primary_ivt == (program_counter >= 23'h000004 &&
    program_counter <= 23'h0000ff)) else $error("primary table");
  a_alt_ivt: assert property (
    in_alternate_ivt == (program_counter >= 23'h000100 &&
    program_counter <= 23'h0001ff)) else $error("alternate table");
  a_cfg_pulse: assert property (
    cfg_rd_req && clk_en |=> !cfg_rd_req) else $error("cfg req length");
  a_cfg_upper: assert property (
    cfg_rd_req || cfg_wr_req |-> cfg_addr[23]) else $error("cfg addr");
  a_cfg_answer: assert property (
    cfg_rd_req && clk_en |=> table_rd_valid) else $error("cfg answer");
  a_cfg_wr_quiet: assert property (
    cfg_wr_req && clk_en |=> !table_rd_valid) else $error("cfg write answer");
endmodule
bind psam_map psam_chk i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .clk_en(clk_en), .pc_step(pc_step), .pc_dir_down(pc_dir_down),
  .pc_load(pc_load), .program_counter(program_counter),
  .fetch_addr(fetch_addr), .in_vector_area(in_vector_area),
  .in_primary_ivt(in_primary_ivt), .in_alternate_ivt(in_alternate_ivt),
  .cfg_rd_req(cfg_rd_req), .cfg_wr_req(cfg_wr_req), .cfg_addr(cfg_addr),
  .table_rd_valid(table_rd_valid));

// >>> test/psam_cfg_model.sv
`timescale 1ns/1ps
// ==================
// config area model
module psam_cfg_model (
  input  wire        core_clk,
  input  wire        cfg_rd_req,
  input  wire [23:0] cfg_addr,
  output wire [15:0] cfg_rd_data
);
  reg tog = 1'b0;
  // idle pattern flips each cycle so stale data never matches
  always @(posedge core_clk) begin
    tog <= ~tog;
  end
  // answer only while the request stands
  assign cfg_rd_data = cfg_rd_req ? cfg_addr[15:0] ^ 16'h3c3c
                                  : {16{tog}} ^ 16'h5a5a;
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
`define CHK(n,e,g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
// ==================
// bench top
module tb;
  reg core_clk = 0, rst_n = 0, clk_en = 1, pc_step = 0, pc_dir_down = 0;
  reg pc_load = 0, rd_op = 0, wr_op = 0, hi = 0;
  reg [22:0] pc_val = 23'h0;
  reg [7:0] page = 8'h00;
  reg [15:0] offs = 16'h0, wdat = 16'h0, q;
  reg cr = 0, cw = 0, dn = 0;
  reg [23:0] cq = 24'h0;
  wire [22:0] pc;
  wire [23:0] fa, ca;
  wire [15:0] rdat, cwd, crd;
  wire vec, pri, alt, rv, den, cacc, crq, cwq;
  int failures = 0, cmp_count = 0;
  psam_map #(.IMPL_AW(4)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .pc_step(pc_step), .pc_dir_down(pc_dir_down),
    .pc_load(pc_load), .pc_load_value(pc_val), .program_counter(pc),
    .fetch_addr(fa), .in_vector_area(vec), .in_primary_ivt(pri),
    .in_alternate_ivt(alt), .table_read_op(rd_op), .table_write_op(wr_op),
    .table_hi_word(hi), .table_page_register(page), .table_offset(offs),
    .table_wr_data(wdat), .table_rd_data(rdat), .table_rd_valid(rv),
    .table_denied(den), .table_cfg_access(cacc), .cfg_rd_req(crq),
    .cfg_wr_req(cwq), .cfg_addr(ca), .cfg_wr_data(cwd), .cfg_rd_data(crd));
  psam_cfg_model i_cfg (.core_clk(core_clk), .cfg_rd_req(crq),
    .cfg_addr(ca), .cfg_rd_data(crd));
  task conclude;
    $display("checks %0d errors %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one-cycle pc request, inputs move on falling edges
  task pcop(input l, s, d, input [22:0] v);
    @(negedge core_clk);
    pc_load = l;
    pc_step = s;
    pc_dir_down = d;
    pc_val = v;
    @(negedge core_clk);
    pc_load = 0;
    pc_step = 0;
  endtask
  task pcchk(input [22:0] e, input ev, ep, ea);
    `CHK("pc", e, pc)
    `CHK("fetch", {1'b0, e}, fa)
    `CHK("vec", ev, vec)
    `CHK("pri", ep, pri)
    `CHK("alt", ea, alt)
  endtask
  // op held over take and busy edges, answer caught within four
  task tbl(input r, w, h, input [7:0] pg, input [15:0] o, d);
    integer i;
    q = 16'hdead;
    @(negedge core_clk);
    rd_op = r;
    wr_op = w;
    hi = h;
    page = pg;
    offs = o;
    wdat = d;
    for (i = 0; i < 4; i++) begin
      @(negedge core_clk);
      if (i == 0) begin
        cr = crq;
        cw = cwq;
        cq = ca;
      end
      if (i == 1) begin
        rd_op = 0;
        wr_op = 0;
        dn = den;
      end
      if (rv === 1'b1) q = rdat;
    end
  endtask
  task t_reset;
    pcchk(23'h0, 1, 0, 0);
  endtask
  task t_pc;
    pcop(1, 0, 0, 23'h1fe);
    pcchk(23'h1fe, 1, 0, 1);
    pcop(0, 1, 0, 0);
    pcchk(23'h200, 0, 0, 0);
    pcop(0, 1, 1, 0);
    pcchk(23'h1fe, 1, 0, 1);
    pcop(1, 0, 0, 23'h0ff);
    pcchk(23'h0fe, 1, 1, 0);
    pcop(0, 1, 0, 0);
    pcchk(23'h100, 1, 0, 1);
    clk_en = 0;
    pcop(0, 1, 0, 0);
    clk_en = 1;
    pcchk(23'h100, 1, 0, 1);
  endtask
  task t_table;
    tbl(0, 1, 0, 8'h00, 16'h0004, 16'hbeef);
    `CHK("wq", 16'hdead, q)
    tbl(0, 1, 1, 8'h00, 16'h0004, 16'h12ab);
    tbl(1, 0, 0, 8'h00, 16'h0004, 16'h0);
    `CHK("lo", 16'hbeef, q)
    `CHK("den", 1'b0, dn)
    `CHK("crq0", 1'b0, cr)
    tbl(1, 0, 1, 8'h00, 16'h0004, 16'h0);
    `CHK("hi", 16'h00ab, q)
    tbl(1, 0, 0, 8'h00, 16'h0100, 16'h0);
    `CHK("gap", 16'h0, q)
    tbl(1, 0, 0, 8'h80, 16'h0010, 16'h0);
    `CHK("cfg", 16'h3c2c, q)
    `CHK("sel", 1'b1, cacc)
    `CHK("crq", 1'b1, cr)
    `CHK("cfa", 24'h800010, cq)
    tbl(0, 1, 0, 8'h80, 16'h0010, 16'h55aa);
    `CHK("cwd", 16'h55aa, cwd)
    `CHK("cwq", 1'b1, cw)
    `CHK("cwa", 16'hdead, q)
  endtask
  // reset again in mid-run, from a state away from the reset values
  task t_rerun;
    @(negedge core_clk);
    rst_n = 0;
    repeat (2) @(negedge core_clk);
    rst_n = 1;
    pcchk(23'h0, 1, 0, 0);
    `CHK("sel0", 1'b0, cacc)
    tbl(1, 0, 0, 8'h00, 16'h0004, 16'h0);
    `CHK("kept", 16'hbeef, q)
  endtask
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // watchdog, run needs well under a microsecond
  initial begin
    #4000;
    failures++;
    conclude;
  end
  initial begin
    repeat (20) @(negedge core_clk);
    rst_n = 1;
    t_reset;
    t_pc;
    t_table;
    t_rerun;
    conclude;
  end
endmodule
